//--- adcs_pkg.sv
// Package for the ADC sequencer with touchscreen control.
// Assumes a 100 MHz APB clock and 32-bit APB data.
`default_nettype none
package adcs_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL0 = 8'h00;
  localparam logic [7:0] OFF_CTRL1 = 8'h04;
  localparam logic [7:0] OFF_DELAY = 8'h08;
  localparam logic [7:0] OFF_THRESH = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_RES01 = 8'h14;
  localparam logic [7:0] OFF_RES67 = 8'h20;
  // Control word fields
  localparam int CFG_W = 15;
  localparam int B_START = 0;
  localparam int B_SINGLE = 1;
  localparam int B_CHAN = 2;
  localparam int B_GRP = 5;
  localparam int B_TRIG_IGN = 6;
  localparam int B_TRIG_EN = 7;
  localparam int B_DLY_EACH = 8;
  localparam int B_PULSE_EN = 9;
  localparam int B_PULSE8 = 10;
  localparam int B_CH7_UID = 11;
  localparam int B_TS = 12;
  localparam int B_THR_EN = 14;
  localparam int B_ALT = 23;
  // Status fields
  localparam int S_BUSY = 0;
  localparam int S_DONE0 = 1;
  localparam int S_DONE1 = 2;
  localparam int S_THR = 3;
  localparam int S_PEN = 4;
  localparam int S_OWNER = 5;
  // Widths and reset values
  localparam int RES_W = 10;
  localparam int DLY_W = 13;
  localparam logic [CFG_W-1:0] CFG_RST = 15'h0000;
  localparam logic [DLY_W-1:0] DLY_RST = 13'h0000;
  localparam logic [RES_W-1:0] THR_RST = 10'h3ff;
  // Timing
  localparam int CLK_NS = 10;
  localparam int US_NS = 1000;
  localparam int TICK_CYC = US_NS / CLK_NS;
  localparam int DLY_MAX_US = 8000;
  localparam int SMP_NS = 200;
  localparam int SMP_CYC = (SMP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STEP_NS = 80;
  localparam int STEP_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS;
  // Touchscreen readout modes
  typedef enum logic [1:0] {TS_OFF = 2'h0, TS_PEN = 2'h1, TS_RES = 2'h2, TS_POS = 2'h3} adcs_ts_t;
endpackage : adcs_pkg
`default_nettype wire

//--- adcs_top.sv
// ADC sequencer: APB registers, two-host arbitration, SAR control,
// result store, threshold compare, pulse output and touchscreen drive.
// Assumes an external analog comparator, DAC and channel multiplexer.
`timescale 1ns/1ps
`default_nettype none
module adcs_top
  import adcs_pkg::*;
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins from outside the clock domain
  input wire logic external_trigger_pin,
  input wire logic sar_comp_in,
  input wire logic pen_contact_in,
  // Analog front end control
  output logic sar_sample,
  output logic [RES_W-1:0] sar_dac,
  output logic [3:0] chan_sel,
  output logic group_select,
  output logic ch7_uid_sel,
  output logic thermistor_bias_en,
  output logic conversion_pulse_out,
  // Touchscreen plate drive
  output logic x_hi_en,
  output logic x_lo_en,
  output logic y_hi_en,
  output logic y_lo_en,
  output logic pen_bias_en,
  // Host notifications
  output logic busy,
  output logic [1:0] done_irq,
  output logic pen_irq
);

  typedef enum logic [1:0] {ST_IDLE, ST_DLY, ST_SMP, ST_CNV} adcs_state_t;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [3:0] chan_of(input logic [CFG_W-1:0] c, input logic [2:0] s);
    logic [2:0] n;
    adcs_ts_t m;
    n = c[B_SINGLE] ? c[B_CHAN+:3] : s;
    m = adcs_ts_t'(c[B_TS+:2]);
    chan_of = {c[B_GRP], n};
    if (m == TS_RES || m == TS_POS) begin
      // X readings sense Y plate in position mode, X plate in resistive
      if (s < 3'h3) begin
        chan_of = (m == TS_POS) ? 4'he : 4'hc;
      end else if (s < 3'h6) begin
        chan_of = (m == TS_POS) ? 4'hc : 4'he;
      end else begin
        chan_of = 4'hd;
      end
    end
  endfunction : chan_of

  function automatic logic [DLY_W-1:0] dly_of(input logic [DLY_W-1:0] d);
    dly_of = (d > DLY_W'(DLY_MAX_US)) ? DLY_W'(DLY_MAX_US) : d;
  endfunction : dly_of

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic trg_s1_q, trg_s2_q, trg_s3_q;
  logic cmp_s1_q, cmp_s2_q;
  logic pen_s1_q, pen_s2_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trg_s1_q <= 1'b0;
      trg_s2_q <= 1'b0;
      trg_s3_q <= 1'b0;
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
      pen_s1_q <= 1'b0;
      pen_s2_q <= 1'b0;
    end else begin
      trg_s1_q <= external_trigger_pin;
      trg_s2_q <= trg_s1_q;
      trg_s3_q <= trg_s2_q;
      cmp_s1_q <= sar_comp_in;
      cmp_s2_q <= cmp_s1_q;
      pen_s1_q <= pen_contact_in;
      pen_s2_q <= pen_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB decode and control registers

  logic [CFG_W-1:0] cfg_q [2];
  logic [DLY_W-1:0] dly_q;
  logic [RES_W-1:0] thr_q;
  logic wr_en, rd_setup, is_ctrl, mapped, tgt;

  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign is_ctrl = (paddr == OFF_CTRL0) || (paddr == OFF_CTRL1);
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= OFF_RES67);
  assign tgt = (paddr == OFF_CTRL1) ^ pwdata[B_ALT];
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q[0] <= CFG_RST;
      cfg_q[1] <= CFG_RST;
    end else if (wr_en && is_ctrl) begin
      cfg_q[tgt] <= {pwdata[CFG_W-1:1], 1'b0};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_q <= DLY_RST;
      thr_q <= THR_RST;
    end else if (wr_en && paddr == OFF_DELAY) begin
      dly_q <= dly_of(pwdata[DLY_W-1:0]);
    end else if (wr_en && paddr == OFF_THRESH) begin
      thr_q <= pwdata[RES_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Requests and arbitration

  adcs_state_t st_q;
  logic [1:0] pend_q, set_req, grant;
  logic last_q, owner_q, trg_set, pin_go, go, go_set;
  logic [CFG_W-1:0] act_q;

  assign trg_set = !cfg_q[0][B_TRIG_EN];
  // Pin edges count only when idle; commands queue instead
  assign pin_go = trg_s2_q && !trg_s3_q && (st_q == ST_IDLE)
      && cfg_q[trg_set][B_TRIG_EN] && !cfg_q[trg_set][B_TRIG_IGN];
  assign set_req[0] = wr_en && is_ctrl && pwdata[B_START] && !tgt;
  assign set_req[1] = wr_en && is_ctrl && pwdata[B_START] && tgt;

  always_comb begin
    go = 1'b0;
    go_set = 1'b0;
    grant = 2'h0;
    if (st_q == ST_IDLE) begin
      if (pin_go) begin
        go = 1'b1;
        go_set = trg_set;
      end else if (pend_q != 2'h0) begin
        go = 1'b1;
        go_set = pend_q[!last_q] ? !last_q : last_q;
        grant[go_set] = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 2'h0;
      last_q <= 1'b1;
    end else begin
      pend_q <= (pend_q & ~grant) | set_req;
      if (go) begin
        last_q <= go_set;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Timebase: one-microsecond enable

  logic [6:0] tick_q;
  logic us_tick;

  assign us_tick = (tick_q == 7'(TICK_CYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q <= 7'h00;
    end else begin
      tick_q <= us_tick ? 7'h00 : tick_q + 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer and SAR

  logic [DLY_W-1:0] cnt_q;
  logic [2:0] slot_q;
  logic [3:0] bit_q;
  logic [RES_W-1:0] sar_q, trial, result;
  logic step, last_bit, store, last_slot, gap;

  assign trial = sar_q | (RES_W'(1) << bit_q);
  assign step = (st_q == ST_CNV) && (cnt_q == DLY_W'(STEP_CYC - 1));
  assign last_bit = (bit_q == 4'h0);
  assign result = cmp_s2_q ? trial : sar_q;
  assign store = step && last_bit;
  assign last_slot = (slot_q == 3'h7);
  assign gap = act_q[B_DLY_EACH] && (dly_q != DLY_RST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
      cnt_q <= DLY_RST;
      slot_q <= 3'h0;
      bit_q <= 4'h0;
      sar_q <= '0;
      act_q <= CFG_RST;
      owner_q <= 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (go) begin
            act_q <= cfg_q[go_set];
            owner_q <= go_set;
            slot_q <= 3'h0;
            cnt_q <= dly_of(dly_q);
            st_q <= (dly_q == DLY_RST) ? ST_SMP : ST_DLY;
          end
        end
        ST_DLY: begin
          if (cnt_q == DLY_RST) begin
            st_q <= ST_SMP;
          end else if (us_tick) begin
            cnt_q <= cnt_q - DLY_W'(1);
          end
        end
        ST_SMP: begin
          if (cnt_q >= DLY_W'(SMP_CYC - 1)) begin
            st_q <= ST_CNV;
            cnt_q <= DLY_RST;
            bit_q <= 4'(RES_W - 1);
            sar_q <= '0;
          end else begin
            cnt_q <= cnt_q + DLY_W'(1);
          end
        end
        ST_CNV: begin
          cnt_q <= step ? DLY_RST : cnt_q + DLY_W'(1);
          if (step) begin
            sar_q <= result;
            bit_q <= bit_q - 4'h1;
            if (last_bit) begin
              slot_q <= slot_q + 3'h1;
              cnt_q <= gap ? dly_of(dly_q) : DLY_RST;
              st_q <= last_slot ? ST_IDLE : (gap ? ST_DLY : ST_SMP);
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Results, threshold and done flags

  logic [RES_W-1:0] res_q [8];
  logic thr_hit_q, pen_q;
  logic [1:0] done_q;
  logic st_clr;

  assign st_clr = wr_en && (paddr == OFF_STATUS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) begin
        res_q[i] <= '0;
      end
    end else if (store) begin
      res_q[slot_q] <= result;
    end
  end

  // Hardware set wins over a same-cycle software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_hit_q <= 1'b0;
      done_q <= 2'h0;
      pen_q <= 1'b0;
    end else begin
      if (store && act_q[B_THR_EN] && result > thr_q) begin
        thr_hit_q <= 1'b1;
      end else if (st_clr && pwdata[S_THR]) begin
        thr_hit_q <= 1'b0;
      end
      for (int i = 0; i < 2; i++) begin
        if (store && last_slot && owner_q == i[0]) begin
          done_q[i] <= 1'b1;
        end else if (st_clr && pwdata[S_DONE0 + i]) begin
          done_q[i] <= 1'b0;
        end
      end
      if (pen_bias_en && pen_s2_q) begin
        pen_q <= 1'b1;
      end else if (st_clr && pwdata[S_PEN]) begin
        pen_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pulse output

  logic pulse_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_q <= 1'b0;
    end else if (st_q == ST_SMP && slot_q == 3'h0 && act_q[B_PULSE_EN]) begin
      pulse_q <= 1'b1;
    end else if (store && (last_slot || (slot_q == 3'h3 && !act_q[B_PULSE8]))) begin
      pulse_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Analog and plate drive outputs

  adcs_ts_t ts_act, ts_idle;
  logic conv;

  assign ts_act = adcs_ts_t'(act_q[B_TS+:2]);
  assign ts_idle = adcs_ts_t'(cfg_q[0][B_TS+:2] | cfg_q[1][B_TS+:2]);
  assign conv = (st_q == ST_SMP) || (st_q == ST_CNV);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sar_sample <= 1'b0;
      sar_dac <= '0;
      chan_sel <= 4'h0;
      group_select <= 1'b0;
      ch7_uid_sel <= 1'b0;
      thermistor_bias_en <= 1'b0;
      conversion_pulse_out <= 1'b0;
      busy <= 1'b0;
      done_irq <= 2'h0;
      pen_irq <= 1'b0;
    end else begin
      sar_sample <= (st_q == ST_SMP);
      sar_dac <= (st_q == ST_CNV) ? trial : '0;
      chan_sel <= chan_of(act_q, slot_q);
      group_select <= act_q[B_GRP];
      ch7_uid_sel <= act_q[B_CH7_UID];
      thermistor_bias_en <= conv;
      conversion_pulse_out <= pulse_q;
      busy <= (st_q != ST_IDLE);
      done_irq <= done_q;
      pen_irq <= pen_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {x_hi_en, x_lo_en, y_hi_en, y_lo_en, pen_bias_en} <= 5'h00;
    end else if (st_q == ST_IDLE) begin
      // Pen bias on Y, X grounded; converter stays idle
      pen_bias_en <= (ts_idle == TS_PEN);
      {x_hi_en, x_lo_en, y_hi_en, y_lo_en} <= {1'b0, ts_idle == TS_PEN, 2'h0};
    end else if (ts_act == TS_RES || ts_act == TS_POS) begin
      pen_bias_en <= 1'b0;
      if (slot_q < 3'h3) begin
        {x_hi_en, x_lo_en, y_hi_en, y_lo_en} <= 4'hc;
      end else if (slot_q < 3'h6) begin
        {x_hi_en, x_lo_en, y_hi_en, y_lo_en} <= 4'h3;
      end else begin
        {x_hi_en, x_lo_en, y_hi_en, y_lo_en} <= 4'h9;
      end
    end else begin
      {x_hi_en, x_lo_en, y_hi_en, y_lo_en, pen_bias_en} <= 5'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, captured in the setup phase

  logic [31:0] rd_d;
  logic [2:0] pair;

  assign pair = 3'((paddr - OFF_RES01) >> 1);

  always_comb begin
    rd_d = 32'h0;
    if (paddr == OFF_CTRL0 || paddr == OFF_CTRL1) begin
      rd_d[CFG_W-1:0] = cfg_q[paddr == OFF_CTRL1];
    end else if (paddr == OFF_DELAY) begin
      rd_d[DLY_W-1:0] = dly_q;
    end else if (paddr == OFF_THRESH) begin
      rd_d[RES_W-1:0] = thr_q;
    end else if (paddr == OFF_STATUS) begin
      rd_d[S_BUSY] = (st_q != ST_IDLE);
      rd_d[S_DONE0] = done_q[0];
      rd_d[S_DONE1] = done_q[1];
      rd_d[S_THR] = thr_hit_q;
      rd_d[S_PEN] = pen_q;
      rd_d[S_OWNER] = owner_q;
    end else if (mapped && paddr >= OFF_RES01) begin
      rd_d[2*RES_W-1:0] = {res_q[pair | 3'h1], res_q[pair]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_setup) begin
      prdata <= rd_d;
    end
  end

endmodule : adcs_top
`default_nettype wire

//--- adcs_top_sva.sv
// Checker for the ADC sequencer: timing relations between its ports.
// Assumes it is bound to adcs_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module adcs_sva
  import adcs_pkg::*;
(
  // Clock, reset and APB request
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  // Converter side
  input wire logic sar_sample,
  input wire logic [RES_W-1:0] sar_dac,
  input wire logic [3:0] chan_sel,
  input wire logic group_select,
  input wire logic thermistor_bias_en,
  input wire logic conversion_pulse_out,
  input wire logic pen_bias_en,
  // Notifications
  input wire logic busy,
  input wire logic [1:0] done_irq
);
  logic start_wr;
  logic stat_wr;
  assign start_wr = psel & penable & pwrite & (paddr == 8'h00 | paddr == 8'h04) & pwdata[0];
  assign stat_wr = psel & penable & pwrite & (paddr == 8'h10);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////
  a_start_busy: assert property (start_wr && !busy |-> ##[1:3] busy)
    else $error("busy did not follow a start");
  a_busy_hold: assert property ($rose(busy) |-> busy [*8])
    else $error("busy dropped early");
  a_idle_dac: assert property (!busy |-> sar_dac == 10'h000)
    else $error("trial code while idle");
  a_done_single: assert property (!($rose(done_irq[0]) && $rose(done_irq[1])))
    else $error("both hosts flagged at once");
  a_done_sticky: assert property (done_irq[0] && !stat_wr && !$past(stat_wr)
    |=> done_irq[0])
    else $error("done flag lost without clear");
  a_group_stable: assert property (busy && $past(busy) |-> $stable(group_select))
    else $error("group changed in a series");
  a_chan_group: assert property (sar_sample |-> chan_sel[3] == group_select)
    else $error("channel outside selected group");
  a_therm_conv: assert property (thermistor_bias_en |-> busy)
    else $error("thermistor bias while idle");
  a_pulse_conv: assert property (conversion_pulse_out |-> busy)
    else $error("pulse outside conversions");
  a_pen_idle: assert property (pen_bias_en |-> !busy)
    else $error("pen bias during conversion");
  c_series: cover property ($rose(busy));
  c_host1_done: cover property ($rose(done_irq[1]));
  c_pulse: cover property ($rose(conversion_pulse_out));
endmodule : adcs_sva
bind adcs_top adcs_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .sar_sample, .sar_dac, .chan_sel, .group_select, .thermistor_bias_en,
  .conversion_pulse_out, .pen_bias_en, .busy, .done_irq);
`default_nettype wire

//--- adcs_afe_model.sv
// Analog front end model: one track and hold plus comparator, fixed level per channel.
// Assumes chan_sel is valid while sar_sample is high.
`timescale 1ns/1ps
`default_nettype none
module adcs_afe_model
  import adcs_pkg::*;
(
  // Converter control
  input wire logic pclk,
  input wire logic sar_sample,
  input wire logic [RES_W-1:0] sar_dac,
  input wire logic [3:0] chan_sel,
  input wire logic ch7_uid_sel,
  // Comparator answer
  output logic sar_comp_in
);
  logic [RES_W-1:0] held_q = 10'h000;
  // Level frozen at end of sampling, so late channel changes are not seen
  always_ff @(posedge pclk) begin
    if (sar_sample) begin
      held_q <= {chan_sel, 6'h15} ^ ((chan_sel == 4'h7 && ch7_uid_sel) ? 10'h0aa : 10'h000);
    end
  end
  assign sar_comp_in = (held_q >= sar_dac);
endmodule : adcs_afe_model
`default_nettype wire

//--- test_adc_sequencer_touchscreen.sv
// Bench for the ADC sequencer: APB tasks, analog model, trigger pin.
// Assumes adcs_pkg, adcs_top and adcs_afe_model compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_adc_sequencer_touchscreen;
  import adcs_pkg::*;
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, sar_comp_in, pen_contact_in = 0, trig_run = 0, lclk = 0;
  logic sar_sample, group_select, ch7_uid_sel, thermistor_bias_en, conversion_pulse_out;
  logic x_hi_en, x_lo_en, y_hi_en, y_lo_en, pen_bias_en, busy, pen_irq, pulse_seen = 0;
  logic external_trigger_pin;
  logic [RES_W-1:0] sar_dac;
  logic [3:0] chan_sel;
  logic [1:0] done_irq;
  logic [3:0] tch [8] = '{4'he, 4'he, 4'he, 4'hc, 4'hc, 4'hc, 4'hd, 4'hd};
  logic [3:0] tres [8] = '{4'hc, 4'hc, 4'hc, 4'he, 4'he, 4'he, 4'hd, 4'hd};
  int fails = 0, checked = 0, cyc = 0, run_n = 0, last_n = 0, pulse_n = 0;
  // Pin edges only inside a burst; idle low between bursts
  assign external_trigger_pin = trig_run & lclk;
  adcs_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .external_trigger_pin, .sar_comp_in, .pen_contact_in, .sar_sample, .sar_dac,
    .chan_sel, .group_select, .ch7_uid_sel, .thermistor_bias_en, .conversion_pulse_out,
    .x_hi_en, .x_lo_en, .y_hi_en, .y_lo_en, .pen_bias_en, .busy, .done_irq, .pen_irq);
  adcs_afe_model afe (.pclk, .sar_sample, .sar_dac, .chan_sel, .ch7_uid_sel, .sar_comp_in);
  ////////////////////////////////////////////////////////////
  always #5 pclk = ~pclk;
  always #62.5 lclk = ~lclk;
  always @(posedge pclk) begin
    cyc++;
    if (conversion_pulse_out === 1'b1) begin
      pulse_seen <= 1'b1;
      pulse_n <= pulse_n + 1;
    end
    if (busy === 1'b1) run_n <= run_n + 1;
    else if (run_n != 0) begin
      last_n <= run_n;
      run_n <= 0;
    end
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [9:0] lvl(input logic [3:0] ch, input logic u);
    return {ch, 6'h15} ^ ((ch == 4'h7 && u) ? 10'h0aa : 10'h000);
  endfunction : lvl
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : rdchk
  task automatic cycles(input int n);
    repeat (n) @(posedge pclk);
  endtask : cycles
  task automatic wait_irq(input int b);
    while (done_irq[b] !== 1'b1) @(posedge pclk);
  endtask : wait_irq
  // Slot s holds channel c0 + s * st
  task automatic chk_res(input logic [3:0] c0, input logic [3:0] st, input logic u);
    for (int k = 0; k < 4; k++) begin
      rdchk(OFF_RES01 + 8'(4 * k), {12'h0, lvl(c0 + 4'(2 * k + 1) * st, u),
        lvl(c0 + 4'(2 * k) * st, u)});
    end
  endtask : chk_res
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 9; i++) begin
      rdchk(8'(4 * i), (i == 3) ? 32'h0000_03ff : 32'h0);
    end
    apb(1'b0, 8'h24, 32'h0);
    `CHK({err, rd}, 33'h1_0000_0000)
    wr_alt();
    // Host 0 scans group 0, accessory on channel 7, threshold on
    apb(1'b1, OFF_THRESH, 32'h100);
    apb(1'b1, OFF_CTRL0, 32'h4e01);
    wait_irq(0);
    `CHK(done_irq, 2'b01)
    `CHK(pulse_seen, 1'b1)
    `CHK(pulse_n >= 780 && pulse_n <= 820, 1'b1)
    chk_res(4'h0, 4'h1, 1'b1);
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK(rd & 32'h1f, 32'h0a)
    apb(1'b1, OFF_STATUS, 32'h1e);
    // Delay clamp, then host 1 repeats channel 11 with delays between
    apb(1'b1, OFF_DELAY, 32'h1fff);
    rdchk(OFF_DELAY, 32'h1f40);
    apb(1'b1, OFF_DELAY, 32'h2);
    apb(1'b1, OFF_CTRL1, 32'h12f);
    wait_irq(1);
    `CHK(done_irq, 2'b10)
    chk_res(4'hb, 4'h0, 1'b0);
    cycles(3);
    `CHK(last_n >= 1500 && last_n <= 2600, 1'b1)
    // Two hosts start back to back; the later one waits its turn
    apb(1'b1, OFF_DELAY, 32'h0);
    apb(1'b1, OFF_STATUS, 32'h1e);
    apb(1'b1, OFF_CTRL0, 32'h1);
    apb(1'b1, OFF_CTRL1, 32'h1);
    wait_irq(0);
    wait_irq(1);
    `CHK(done_irq, 2'b11)
    apb(1'b1, OFF_STATUS, 32'h1e);
    // Trigger pin, first ignored, then honoured once
    apb(1'b1, OFF_CTRL0, 32'hc0);
    trig_run <= 1'b1;
    cycles(100);
    trig_run <= 1'b0;
    `CHK(busy, 1'b0)
    apb(1'b1, OFF_CTRL0, 32'h80);
    trig_run <= 1'b1;
    cycles(100);
    trig_run <= 1'b0;
    `CHK(busy, 1'b1)
    wait_irq(0);
    cycles(20);
    `CHK(busy, 1'b0)
    apb(1'b1, OFF_STATUS, 32'h1e);
    // Pen detect while idle
    apb(1'b1, OFF_CTRL0, 32'h1000);
    cycles(5);
    `CHK(pen_bias_en, 1'b1)
    `CHK({x_hi_en, x_lo_en, y_hi_en, y_lo_en}, 4'h4)
    pen_contact_in <= 1'b1;
    cycles(10);
    pen_contact_in <= 1'b0;
    `CHK(pen_irq, 1'b1)
    apb(1'b1, OFF_STATUS, 32'h1e);
    // Position mode readout
    apb(1'b1, OFF_CTRL0, 32'h3021);
    cycles(50);
    `CHK({x_hi_en, x_lo_en, y_hi_en, y_lo_en}, 4'hc)
    wait_irq(0);
    for (int k = 0; k < 4; k++) begin
      rdchk(OFF_RES01 + 8'(4 * k), {12'h0, lvl(tch[2 * k + 1], 1'b0), lvl(tch[2 * k], 1'b0)});
    end
    // Resistive mode, pulse over four conversions only
    apb(1'b1, OFF_STATUS, 32'h1e);
    apb(1'b1, OFF_CTRL0, 32'h2221);
    cycles(50);
    `CHK({x_hi_en, x_lo_en, y_hi_en, y_lo_en}, 4'hc)
    wait_irq(0);
    for (int k = 0; k < 4; k++) begin
      rdchk(OFF_RES01 + 8'(4 * k), {12'h0, lvl(tres[2 * k + 1], 1'b0), lvl(tres[2 * k], 1'b0)});
    end
    `CHK(pulse_n >= 1170 && pulse_n <= 1230, 1'b1)
    tally_and_finish();
  end
  // Bit 23 steers the word to the other host's set and reads as zero
  task automatic wr_alt();
    apb(1'b1, OFF_CTRL0, 32'h0080_0200);
    rdchk(OFF_CTRL0, 32'h0);
    rdchk(OFF_CTRL1, 32'h200);
    apb(1'b1, OFF_CTRL1, 32'h0);
  endtask : wr_alt
endmodule : test_adc_sequencer_touchscreen
`default_nettype wire
